// ==== design/hsft_pkg.sv ====
// package of constants and carrier types for the hot swap fault timer
package hsft_pkg;

   // timing node modelled as a counter: full scale stands for the upper level
   localparam int unsigned NODE_W          = 16;
   localparam logic [15:0] NODE_UPPER      = 16'h1388; // 1.0 V, 5000 steps
   localparam logic [15:0] NODE_LOWER      = 16'h03E8; // 0.2 V, 1000 steps
   localparam logic [15:0] NODE_ZERO       = 16'h0000;
   // step sizes per clock, scaled from the four node currents
   localparam logic [15:0] STEP_SLOW_UP    = 16'h0003; // 3 uA pull-up
   localparam logic [15:0] STEP_FAST_UP    = 16'h003C; // 60 uA pull-up
   localparam logic [15:0] STEP_SLOW_DN    = 16'h0002; // 2 uA pull-down
   localparam logic [15:0] STEP_FAST_DN    = 16'h0064; // 100 uA pull-down
   // short reset held after the lockout releases
   localparam real         POR_HOLD_NS     = 100.0;
   localparam real         CLK_PERIOD_NS   = 4.0;
   localparam int unsigned POR_HOLD_CYC    =
      (POR_HOLD_NS / CLK_PERIOD_NS) < 1.0 ? 1 :
      int'($ceil(POR_HOLD_NS / CLK_PERIOD_NS));
   // severe overcurrent must be controlled within 1 us
   localparam real         SEVERE_MAX_NS   = 1000.0;
   localparam int unsigned SEVERE_MAX_CYC  =
      int'($floor(SEVERE_MAX_NS / CLK_PERIOD_NS));
   localparam int unsigned POR_W           = 8;

   // node current selection
   typedef enum logic [2:0]
   {
      HSFT_NODE_HOLD    = 3'b000,
      HSFT_NODE_SLOW_UP = 3'b001,
      HSFT_NODE_FAST_UP = 3'b010,
      HSFT_NODE_SLOW_DN = 3'b011,
      HSFT_NODE_FAST_DN = 3'b100,
      HSFT_NODE_CLEAR   = 3'b101
   } hsft_node_t;

   // sequencer states
   typedef enum logic [3:0]
   {
      HSFT_ST_RESET    = 4'h0,
      HSFT_ST_INIT_UP  = 4'h1,
      HSFT_ST_INIT_DN  = 4'h2,
      HSFT_ST_READY    = 4'h3,
      HSFT_ST_ON       = 4'h4,
      HSFT_ST_LIMIT    = 4'h5,
      HSFT_ST_COOL     = 4'h6,
      HSFT_ST_LATCH_DN = 4'h7,
      HSFT_ST_LATCHED  = 4'h8,
      HSFT_ST_RETRY_DN = 4'h9
   } hsft_state_t;

   // comparator inputs from the supply and current monitors
   typedef struct packed
   {
      logic lockout;
      logic under_ok;
      logic over_ok;
      logic enable;
      logic bus_on;
      logic breaker_trip;
      logic severe_oc;
      logic fb_above;
      logic fb_below_hyst;
   } hsft_mon_t;

   // drive outputs toward the pass switch and open-drain pins
   typedef struct packed
   {
      logic gate_on;
      logic gate_regulate;
      logic gate_strong_off;
      logic gate_fast_off;
      logic fault_latch_n_oe;
      logic output_good_oe;
      logic hyst_source_on;
      logic node_clear;
   } hsft_drv_t;

endpackage : hsft_pkg

// ==== design/hsft_node_counter.sv ====
// up/down counter standing for the timing capacitor and its comparators
`timescale 1ns/1ps
module hsft_node_counter
#(
   parameter logic [15:0] UPPER = hsft_pkg::NODE_UPPER,
   parameter logic [15:0] LOWER = hsft_pkg::NODE_LOWER
)
(
   // clock and control
   input  wire logic              clk_sys,
   input  wire logic              reset_n,
   input  wire logic              clk_en,
   // current selection
   input  wire hsft_pkg::hsft_node_t sel,
   // node level and comparators
   output logic [15:0]            level_q,
   output logic                   at_upper,
   output logic                   below_lower
);

   logic [15:0] level_d;
   logic [16:0] sum_up;
   logic [15:0] step_up;
   logic [15:0] step_dn;

   // current picked from the selection; holding keeps the level
   assign step_up = (sel == hsft_pkg::HSFT_NODE_FAST_UP) ?
                    hsft_pkg::STEP_FAST_UP : hsft_pkg::STEP_SLOW_UP;
   assign step_dn = (sel == hsft_pkg::HSFT_NODE_FAST_DN) ?
                    hsft_pkg::STEP_FAST_DN : hsft_pkg::STEP_SLOW_DN;
   assign sum_up  = {1'b0, level_q} + {1'b0, step_up};

   // saturate at the terminal counts so comparators see clean crossings
   always_comb
   begin
      level_d = level_q;
      case (sel)
         hsft_pkg::HSFT_NODE_SLOW_UP,
         hsft_pkg::HSFT_NODE_FAST_UP:
            level_d = (sum_up[15:0] >= UPPER || sum_up[16]) ?
                      UPPER : sum_up[15:0];
         hsft_pkg::HSFT_NODE_SLOW_DN,
         hsft_pkg::HSFT_NODE_FAST_DN:
            level_d = (level_q > step_dn) ?
                      16'(level_q - step_dn) : hsft_pkg::NODE_ZERO;
         hsft_pkg::HSFT_NODE_CLEAR:
            level_d = hsft_pkg::NODE_ZERO;
         default:
            level_d = level_q;
      endcase
   end

   // node state register
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         level_q <= hsft_pkg::NODE_ZERO;
      else if (clk_en)
         level_q <= level_d;
   end

   // two comparators on the node
   assign at_upper    = (level_q >= UPPER);
   assign below_lower = (level_q <  LOWER);

endmodule : hsft_node_counter

// ==== design/hsft_sequencer.sv ====
// hot swap sequencer: reset hold, initial cycle, fault timer, power good
// Operation
// - hold gate and timing node low during lockout and the short reset
// - initial cycle: slow charge to upper level, fast discharge to lower
// - after initial cycle, ready at lower level; supply monitors are checked at turn-on and all the while the switch is on
// - breaker trip starts fast charge and puts gate into current limiting
// - trip clears before upper level: stop fast charge, slow discharge
// - trip persists to upper level: gate off, fault latch low at once
// - latch-off: slow discharge at upper level, latch low, refuse turn-on
// - below lower level after latch-off, re-enable by input or bus toggle
// - autoretry: slow discharge after fault, restart at lower level
// - retries repeat forever; system stops them by holding inputs low
// - severe overcurrent detector forces current control within 1 us
// - undervoltage below reference shuts gate with strong pull-down
// - overvoltage above reference shuts gate with strong pull-down
// - power-up only with enable high and both supply monitors in range
// - output good pulls low below threshold minus hyst, releases above threshold
// - hysteresis source on above threshold, off below threshold minus hyst
// - two node comparators at lower and upper level drive the timer
`timescale 1ns/1ps
module hsft_sequencer
#(
   parameter int unsigned POR_CYC = hsft_pkg::POR_HOLD_CYC
)
(
   // clock, reset, enable
   input  wire logic               clk_sys,
   input  wire logic               reset_n,
   input  wire logic               clk_en,
   // monitor comparators and mode strap
   input  wire hsft_pkg::hsft_mon_t mon,
   input  wire logic               autoretry,
   // gate and pin drives, state and node level
   output hsft_pkg::hsft_drv_t     drv_q,
   output hsft_pkg::hsft_state_t   state_q,
   output logic [15:0]             node_level_q
);

   hsft_pkg::hsft_state_t state_d;
   hsft_pkg::hsft_node_t  node_sel;
   hsft_pkg::hsft_drv_t   drv_d;
   logic [hsft_pkg::POR_W-1:0] por_q;
   logic [hsft_pkg::POR_W-1:0] por_d;
   logic [15:0] level;
   logic        at_upper;
   logic        below_lower;
   logic        supply_ok;
   logic        run_ok;
   logic        run_ok_q;
   logic        rearm_q;
   logic        rearm_d;
   logic        por_done;
   logic        hyst_q;
   logic        hyst_d;

   // timing node with its comparators
   hsft_node_counter u_node
   (
      .clk_sys     (clk_sys),
      .reset_n     (reset_n),
      .clk_en      (clk_en),
      .sel         (node_sel),
      .level_q     (level),
      .at_upper    (at_upper),
      .below_lower (below_lower)
   );

   // supply window and run qualifiers
   assign supply_ok = mon.under_ok & mon.over_ok;
   assign run_ok    = supply_ok & mon.enable & mon.bus_on;
   assign por_done  = (por_q >= POR_W_CYC());

   function automatic logic [hsft_pkg::POR_W-1:0] POR_W_CYC();
      POR_W_CYC = hsft_pkg::POR_W'(POR_CYC);
   endfunction : POR_W_CYC

   // short reset counter, restarted whenever lockout is active
   assign por_d = mon.lockout ? '0 :
                  (por_done ? por_q : por_q + 1'b1);

   // a falling run qualifier arms re-enable after latch-off
   assign rearm_d = (state_q == hsft_pkg::HSFT_ST_LATCHED) ?
                    (rearm_q | (run_ok_q & ~run_ok)) : 1'b0;

   // hysteresis state for output good, set wins over clear
   assign hyst_d = mon.fb_above ? 1'b1 :
                   (mon.fb_below_hyst ? 1'b0 : hyst_q);

   // next state and node current selection
   always_comb
   begin
      state_d  = state_q;
      node_sel = hsft_pkg::HSFT_NODE_HOLD;
      case (state_q)
         hsft_pkg::HSFT_ST_RESET:
         begin
            node_sel = hsft_pkg::HSFT_NODE_CLEAR;
            if (por_done)
               state_d = hsft_pkg::HSFT_ST_INIT_UP;
         end
         hsft_pkg::HSFT_ST_INIT_UP:
         begin
            node_sel = hsft_pkg::HSFT_NODE_SLOW_UP;
            if (at_upper)
               state_d = hsft_pkg::HSFT_ST_INIT_DN;
         end
         hsft_pkg::HSFT_ST_INIT_DN:
         begin
            node_sel = hsft_pkg::HSFT_NODE_FAST_DN;
            if (below_lower)
               state_d = hsft_pkg::HSFT_ST_READY;
         end
         hsft_pkg::HSFT_ST_READY:
         begin
            if (run_ok)
               state_d = hsft_pkg::HSFT_ST_ON;
         end
         hsft_pkg::HSFT_ST_ON,
         hsft_pkg::HSFT_ST_COOL:
         begin
            if (state_q == hsft_pkg::HSFT_ST_COOL)
               node_sel = hsft_pkg::HSFT_NODE_SLOW_DN;
            if (!run_ok)
               state_d = hsft_pkg::HSFT_ST_READY;
            else if (mon.breaker_trip || mon.severe_oc)
               state_d = hsft_pkg::HSFT_ST_LIMIT;
         end
         hsft_pkg::HSFT_ST_LIMIT:
         begin
            node_sel = hsft_pkg::HSFT_NODE_FAST_UP;
            if (!run_ok)
               state_d = hsft_pkg::HSFT_ST_READY;
            else if (at_upper)
               state_d = autoretry ? hsft_pkg::HSFT_ST_RETRY_DN :
                         hsft_pkg::HSFT_ST_LATCH_DN;
            else if (!mon.breaker_trip && !mon.severe_oc)
               state_d = hsft_pkg::HSFT_ST_COOL;
         end
         hsft_pkg::HSFT_ST_LATCH_DN:
         begin
            node_sel = hsft_pkg::HSFT_NODE_SLOW_DN;
            if (below_lower)
               state_d = hsft_pkg::HSFT_ST_LATCHED;
         end
         hsft_pkg::HSFT_ST_LATCHED:
         begin
            if (rearm_q && run_ok)
               state_d = hsft_pkg::HSFT_ST_ON;
         end
         hsft_pkg::HSFT_ST_RETRY_DN:
         begin
            node_sel = hsft_pkg::HSFT_NODE_SLOW_DN;
            if (below_lower)
               state_d = run_ok ? hsft_pkg::HSFT_ST_ON :
                         hsft_pkg::HSFT_ST_READY;
         end
         default:
            state_d = hsft_pkg::HSFT_ST_RESET;
      endcase
      if (mon.lockout)
      begin
         state_d  = hsft_pkg::HSFT_ST_RESET;
         node_sel = hsft_pkg::HSFT_NODE_CLEAR;
      end
   end

   // gate drive follows the next state so outputs react in the same edge
   always_comb
   begin
      drv_d = '0;
      drv_d.gate_on = ((state_d == hsft_pkg::HSFT_ST_ON) ||
                       (state_d == hsft_pkg::HSFT_ST_COOL) ||
                       (state_d == hsft_pkg::HSFT_ST_LIMIT)) &&
                      run_ok && !mon.lockout;
      drv_d.gate_regulate   = drv_d.gate_on &&
                              (state_d == hsft_pkg::HSFT_ST_LIMIT);
      drv_d.gate_strong_off = !supply_ok;
      drv_d.gate_fast_off   = drv_d.gate_on && mon.severe_oc;
      drv_d.fault_latch_n_oe = (state_d == hsft_pkg::HSFT_ST_LATCH_DN) ||
                               (state_d == hsft_pkg::HSFT_ST_LATCHED) ||
                               (state_d == hsft_pkg::HSFT_ST_RETRY_DN);
      drv_d.output_good_oe  = !hyst_d;
      drv_d.hyst_source_on  = hyst_d;
      drv_d.node_clear      = (state_d == hsft_pkg::HSFT_ST_RESET);
   end

   // state and output registers; the 1 us severe bound is met in one cycle
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         state_q  <= hsft_pkg::HSFT_ST_RESET;
         drv_q    <= '0;
         por_q    <= '0;
         run_ok_q <= 1'b0;
         rearm_q  <= 1'b0;
         hyst_q   <= 1'b0;
      end
      else if (clk_en)
      begin
         state_q  <= state_d;
         drv_q    <= drv_d;
         por_q    <= por_d;
         run_ok_q <= run_ok;
         rearm_q  <= rearm_d;
         hyst_q   <= hyst_d;
      end
   end

   // node level as a registered copy for observation
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         node_level_q <= hsft_pkg::NODE_ZERO;
      else if (clk_en)
         node_level_q <= level;
   end

endmodule : hsft_sequencer

// ==== dv/hsft_switch_model.sv ====
// pass switch, short-circuit load and output divider model
`timescale 1ns/1ps
module hsft_switch_model
(
   // clock, sequencer gate drives and bench short command
   input  wire logic clk_sys,
   input  wire logic gate_on,
   input  wire logic gate_regulate,
   input  wire logic short_cmd,
   // sensed back to the sequencer
   output logic      breaker_trip,
   output logic      fb_above,
   output logic      fb_below_hyst
);
   logic [3:0] ramp_q;
   // output rises over a few cycles; the divider lags the switch
   always @(posedge clk_sys)
      ramp_q <= !gate_on ? 4'h0 : (ramp_q == 4'hF) ? ramp_q : ramp_q + 4'h1;
   // a short only draws trip current while the switch conducts
   assign breaker_trip  = (gate_on || gate_regulate) && short_cmd;
   assign fb_above      = ramp_q > 4'h8;
   assign fb_below_hyst = ramp_q < 4'h4;
endmodule : hsft_switch_model

// ==== dv/hsft_sequencer_sva.sv ====
// assertions on the hot swap sequencer ports
`timescale 1ns/1ps
module hsft_sequencer_sva
#(
   parameter int unsigned POR_CYC = 25
)
(
   // clock and control
   input wire logic                  clk_sys,
   input wire logic                  reset_n,
   input wire logic                  clk_en,
   // monitors and mode
   input wire hsft_pkg::hsft_mon_t   mon,
   input wire logic                  autoretry,
   // drives and status
   input wire hsft_pkg::hsft_drv_t   drv_q,
   input wire hsft_pkg::hsft_state_t state_q,
   input wire logic [15:0]           node_level_q
);
   // every condition that lets the switch run
   wire run_ok = clk_en && !mon.lockout && mon.under_ok && mon.over_ok
      && mon.enable && mon.bus_on;
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   lock_hold_a: assert property (mon.lockout && clk_en |=>
      state_q == hsft_pkg::HSFT_ST_RESET && !drv_q.gate_on)
      else $error("gate not held in lockout");
   ready_off_a: assert property (state_q == hsft_pkg::HSFT_ST_READY
      |-> !drv_q.gate_on) else $error("gate on while ready");
   on_cause_a: assert property ($rose(state_q == hsft_pkg::HSFT_ST_ON)
      |-> $past(run_ok)) else $error("switch on without run conditions");
   trip_limit_a: assert property (run_ok && mon.breaker_trip &&
      state_q == hsft_pkg::HSFT_ST_ON |=> drv_q.gate_regulate)
      else $error("trip did not start limiting");
   trip_clear_a: assert property (run_ok && !mon.breaker_trip &&
      !mon.severe_oc && state_q == hsft_pkg::HSFT_ST_LIMIT &&
      node_level_q < 16'h1000 |=> state_q == hsft_pkg::HSFT_ST_COOL)
      else $error("no slow discharge after trip clears");
   fault_off_a: assert property ($rose(drv_q.fault_latch_n_oe)
      |-> !drv_q.gate_on) else $error("latch low with gate on");
   latch_hold_a: assert property (state_q == hsft_pkg::HSFT_ST_LATCH_DN
      |-> drv_q.fault_latch_n_oe && !drv_q.gate_on)
      else $error("latch-off discharge not held off");
   supply_off_a: assert property (clk_en &&
      !(mon.under_ok && mon.over_ok) |=> !drv_q.gate_on)
      else $error("gate on outside supply window");
   enable_off_a: assert property (clk_en && !mon.enable
      |=> !drv_q.gate_on) else $error("gate on with enable low");
   good_rel_a: assert property (clk_en && !mon.lockout && mon.fb_above
      |=> !drv_q.output_good_oe && drv_q.hyst_source_on)
      else $error("output good not released");
   severe_a: assert property (clk_en && mon.severe_oc &&
      state_q == hsft_pkg::HSFT_ST_ON |-> ##[1:250]
      (drv_q.gate_fast_off || !drv_q.gate_on))
      else $error("severe overcurrent not controlled");
endmodule : hsft_sequencer_sva

bind hsft_sequencer hsft_sequencer_sva #(.POR_CYC(POR_CYC)) i_hsft_sva
(
   .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .mon(mon),
   .autoretry(autoretry), .drv_q(drv_q), .state_q(state_q),
   .node_level_q(node_level_q)
);

// ==== dv/hsft_sequencer_tb.sv ====
// self-checking bench for the hot swap sequencer
`timescale 1ns/1ps
module hsft_sequencer_tb;
   logic                  clk_sys = 1'b0;
   logic                  reset_n = 1'b0;
   logic                  clk_en = 1'b1;
   logic                  lock = 1'b1, uv = 1'b1, ov = 1'b1, en = 1'b0;
   logic                  bus = 1'b1, sev = 1'b0, shrt = 1'b0, rty = 1'b0;
   logic                  trip, fb_hi, fb_lo;
   hsft_pkg::hsft_mon_t   mon;
   hsft_pkg::hsft_drv_t   drv_q;
   hsft_pkg::hsft_state_t state_q;
   logic [15:0]           lvl;
   int                    error_cnt = 0;
   int                    total_checks = 0;
   int                    n;
   // 250 MHz clock and monitor bundle
   always #2 clk_sys = ~clk_sys;
   assign mon = {lock, uv, ov, en, bus, trip, sev, fb_hi, fb_lo};
   hsft_sequencer i_hsft_sequencer (.clk_sys(clk_sys), .reset_n(reset_n),
      .clk_en(clk_en), .mon(mon), .autoretry(rty), .drv_q(drv_q),
      .state_q(state_q), .node_level_q(lvl));
   hsft_switch_model i_hsft_switch_model (.clk_sys(clk_sys),
      .gate_on(drv_q.gate_on), .gate_regulate(drv_q.gate_regulate),
      .short_cmd(shrt), .breaker_trip(trip), .fb_above(fb_hi),
      .fb_below_hyst(fb_lo));
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      total_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // bounded wait for a state; n keeps the cycles it took
   task automatic wt(input hsft_pkg::hsft_state_t st, input int lim);
      n = 0;
      #1;
      while (state_q !== st && n < lim)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk("state", st, state_q);
      if (state_q !== st)
         test_done();
   endtask : wt
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask : cyc
   task automatic t_init();
      cyc(5);
      chk("gate in lockout", 0, drv_q.gate_on);
      chk("node in lockout", 0, lvl);
      chk("node clear", 1, drv_q.node_clear);
      @(posedge clk_sys) lock <= 1'b0;
      wt(hsft_pkg::HSFT_ST_INIT_UP, 40);
      wt(hsft_pkg::HSFT_ST_INIT_DN, 1800);
      chk("slow charge", 1, 16'(n >= 1665 && n <= 1669));
      wt(hsft_pkg::HSFT_ST_READY, 60);
      chk("fast discharge", 1, 16'(n >= 38 && n <= 44));
      cyc(30);
      chk("enable low", hsft_pkg::HSFT_ST_READY, state_q);
      @(posedge clk_sys) en <= 1'b1;
      wt(hsft_pkg::HSFT_ST_ON, 5);
      cyc(20);
      chk("switch on", 1, drv_q.gate_on);
      chk("good released", 0, drv_q.output_good_oe);
      chk("hysteresis", 1, drv_q.hyst_source_on);
      chk("node free", 0, drv_q.node_clear);
      $display("init and power-up done");
   endtask : t_init
   task automatic t_fault();
      @(posedge clk_sys) shrt <= 1'b1;
      wt(hsft_pkg::HSFT_ST_LIMIT, 5);
      cyc(1);
      chk("regulating", 1, drv_q.gate_regulate);
      cyc(40);
      @(posedge clk_sys) shrt <= 1'b0;
      wt(hsft_pkg::HSFT_ST_COOL, 5);
      chk("no latch", 0, drv_q.fault_latch_n_oe);
      // cool-down keeps the switch on while the node decays slowly
      n = 0;
      while (lvl >= hsft_pkg::NODE_LOWER && n < 1600)
      begin
         cyc(1);
         n++;
      end
      chk("cooled", 1, 16'(n < 1600));
      chk("still on", 1, drv_q.gate_on);
      chk("still cool", hsft_pkg::HSFT_ST_COOL, state_q);
      if (n >= 1600)
         test_done();
      @(posedge clk_sys) shrt <= 1'b1;
      wt(hsft_pkg::HSFT_ST_LATCH_DN, 120);
      chk("latch low", 1, drv_q.fault_latch_n_oe);
      chk("gate off", 0, drv_q.gate_on);
      @(posedge clk_sys) shrt <= 1'b0;
      @(posedge clk_sys) bus <= 1'b0;
      @(posedge clk_sys) bus <= 1'b1;
      cyc(3);
      chk("refused", hsft_pkg::HSFT_ST_LATCH_DN, state_q);
      wt(hsft_pkg::HSFT_ST_LATCHED, 2200);
      cyc(20);
      chk("stays off", hsft_pkg::HSFT_ST_LATCHED, state_q);
      @(posedge clk_sys) uv <= 1'b0;
      @(posedge clk_sys) uv <= 1'b1;
      wt(hsft_pkg::HSFT_ST_ON, 10);
      $display("limit and latch-off done");
   endtask : t_fault
   task automatic t_retry();
      @(posedge clk_sys)
      begin
         rty <= 1'b1;
         shrt <= 1'b1;
      end
      wt(hsft_pkg::HSFT_ST_RETRY_DN, 120);
      wt(hsft_pkg::HSFT_ST_ON, 2200);
      wt(hsft_pkg::HSFT_ST_RETRY_DN, 120);
      @(posedge clk_sys) en <= 1'b0;
      cyc(2200);
      chk("retry stopped", 0, drv_q.gate_on);
      chk("idle", hsft_pkg::HSFT_ST_READY, state_q);
      chk("good low", 1, drv_q.output_good_oe);
      chk("hyst off", 0, drv_q.hyst_source_on);
      @(posedge clk_sys)
      begin
         shrt <= 1'b0;
         en <= 1'b1;
      end
      wt(hsft_pkg::HSFT_ST_ON, 5);
      $display("autoretry done");
   endtask : t_retry
   task automatic t_supply();
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk_sys)
         begin
            uv <= (k != 0);
            ov <= (k == 0);
         end
         cyc(2);
         chk("gate off", 0, drv_q.gate_on);
         chk("strong off", 1, drv_q.gate_strong_off);
         @(posedge clk_sys)
         begin
            uv <= 1'b1;
            ov <= 1'b1;
         end
         wt(hsft_pkg::HSFT_ST_ON, 5);
      end
      cyc(20);
      @(posedge clk_sys) sev <= 1'b1;
      n = 0;
      #1;
      while (drv_q.gate_fast_off !== 1'b1 && drv_q.gate_on !== 1'b0 &&
             n < 250)
      begin
         cyc(1);
         n++;
      end
      chk("severe", 1, 16'(n < 250));
      if (n >= 250)
         test_done();
      @(posedge clk_sys) sev <= 1'b0;
      $display("supply and severe done");
   endtask : t_supply
   // reset for ten cycles, then the scenarios in turn
   initial
   begin
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_init();
      t_fault();
      t_retry();
      t_supply();
      test_done();
   end
endmodule : hsft_sequencer_tb
